// File: rtl/ecgate_cfg.svh
// Offsets, field positions, reset values and fixed codes of the gate block
`ifndef ECGATE_CFG_SVH
`define ECGATE_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ECG_CTRL_OFS 8'h00
`define ECG_CNT_OFS 8'h04
`define ECG_PCMP_OFS 8'h08
`define ECG_PDAT_OFS 8'h0c
`define ECG_COUNT_OFS 8'h10
`define ECG_ISTAT_OFS 8'h14
`define ECG_IMASK_OFS 8'h18
`define ECG_VEC_OFS 8'h1c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ECG_PGS_BIT 0
`define ECG_EDGE_LSB 1
`define ECG_PCLK_LSB 3
`define ECG_UCE_BIT 0
`define ECG_LCE_BIT 1
`define ECG_URL_BIT 2
`define ECG_LRL_BIT 3
`define ECG_SPLIT_BIT 4
`define ECG_LSRC_LSB 5
`define ECG_IRQ_GATE 0
`define ECG_IRQ_OVU 1
`define ECG_IRQ_OVL 2
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define ECG_PCMP_RST 16'hffff
`define ECG_PDAT_RST 16'h0000
`define ECG_EDGE_FALL 2'b00
`define ECG_EDGE_RISE 2'b01
`define ECG_PCLK_MAX 3'h5
`define ECG_VEC_NUM 8'h06
`define ECG_VEC_ADDR 16'h000c
`endif

// File: rtl/ecgate_pkg.sv
// Types shared by the gate block files
package ecgate_pkg;
    // System operating modes seen by the block
    typedef enum logic [2:0] {
        PM_ACTIVE = 3'b000,
        PM_SLEEP = 3'b001,
        PM_WATCH = 3'b010,
        PM_SUBACTIVE = 3'b011,
        PM_SUBSLEEP = 3'b100,
        PM_STANDBY = 3'b101
    } power_mode_type;
endpackage

// File: rtl/pulse_gen_core.sv
// Periodic gate pulse generator with compare and data values
`timescale 1ns/10ps
module pulse_gen_core #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic run,
    input wire logic hold,
    input wire logic tick,
    input wire logic [WIDTH-1:0] compareValue,
    input wire logic [WIDTH-1:0] dataValue,
    // Output
    output logic pulseOut
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic pulseOut_reg;
    logic pulseOut_next;

    // Count 0..compare then restart; low while at or below data
    always_comb begin
        count_next = count_reg;
        if (!run) begin
            count_next = '0;
        end else if (!hold && tick) begin
            if (count_reg == compareValue) begin
                count_next = '0;
            end else begin
                count_next = count_reg + 1'b1;
            end
        end
        pulseOut_next = run && (count_next > dataValue);
    end

    // Hold freezes the waveform mid-period instead of restarting it
    always_ff @(posedge clk) begin
        if (reset) begin
            count_reg <= '0;
            pulseOut_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            pulseOut_reg <= pulseOut_next;
        end
    end

    assign pulseOut = pulseOut_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    off_to_on_a: assert property (@(posedge clk) disable iff (reset)
        (run && !hold && tick && count_reg == dataValue && dataValue < compareValue) |=> pulseOut_reg)
        else $error("pulse did not rise after off period");
    period_wrap_a: assert property (@(posedge clk) disable iff (reset)
        (run && !hold && tick && count_reg == compareValue) |=> (count_reg == '0 && !pulseOut_reg))
        else $error("pulse period did not restart");
endmodule

// File: rtl/event_counter_gate.sv
// Event counter gating, pulse gate generator, interrupts and APB registers
//
// Overview of operation
// - Pulse select high: count only while pulse high
// - One gate drives both counters together
// - Pulse source shares interrupt vector six
// - Gate event sets flag; enable forwards request
// - Gate interrupt on rising, falling or both
// - Off is T(data+1), period T(compare+1)
// - Gate from pin or pulse; one-count error
// - Watch/standby: events count, overflow flags untouched
// - Low-power modes: only async events count
// - Watch/standby: pin gates, raises no interrupt
// - Module standby stops counters, holds registers
// - Gate interrupt synchronised, one cycle skew
// - Pulse select low: count only while pin high
`timescale 1ns/10ps
`include "ecgate_cfg.svh"
module event_counter_gate #(
    parameter int ADDR_WIDTH = 8,
    parameter int PULSE_WIDTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System mode
    input wire ecgate_pkg::power_mode_type powerMode,
    input wire logic moduleStandby,
    // Pins and events
    input wire logic externalGatePin,
    input wire logic upperEventInput,
    input wire logic lowerEventInput,
    // Status outputs
    output logic internalPulseOutput,
    output logic [7:0] upperEventCount,
    output logic [7:0] lowerEventCount,
    output logic irq
);
    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // One-cycle enable for phi/2^(sel+1) from the free prescaler
    function automatic logic divTick(input logic [5:0] cnt, input logic [2:0] sel);
        logic [6:0] full;
        logic [5:0] mask;
        full = (7'h02 << sel) - 7'h01;
        mask = full[5:0];
        divTick = ((cnt & mask) == mask);
    endfunction

    // Edge choice for the gate interrupt
    function automatic logic edgeHit(input logic [1:0] sel, input logic rise, input logic fall);
        case (sel)
            `ECG_EDGE_FALL: edgeHit = fall;
            `ECG_EDGE_RISE: edgeHit = rise;
            default: edgeHit = rise || fall;
        endcase
    endfunction

    // ----------------------------------------
    // Registers and internal signals
    // ----------------------------------------
    logic pulseGateSelect_reg;
    logic [1:0] gateEdgeSel_reg;
    logic [2:0] pulseClkSel_reg;
    logic upperCountEnable_reg;
    logic lowerCountEnable_reg;
    logic upperRelease_reg;
    logic lowerRelease_reg;
    logic splitMode_reg;
    logic [1:0] lowerSrc_reg;
    logic [PULSE_WIDTH-1:0] pulseCompare_reg;
    logic [PULSE_WIDTH-1:0] pulseData_reg;
    logic [2:0] irqStatus_reg;
    logic [2:0] irqMask_reg;
    logic [7:0] upperCount_reg;
    logic [7:0] lowerCount_reg;
    logic [5:0] prescale_reg;
    logic gatePrev_reg;
    logic upperEvtPrev_reg;
    logic lowerEvtPrev_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    logic wrEn;
    logic [ADDR_WIDTH-1:0] wrAddr;
    logic lowPower;
    logic watchStby;
    logic pulseOut;
    logic gateSignal;
    logic gateEvent;
    logic irqAllowed;
    logic upperEdge;
    logic lowerEdge;
    logic lowerSrcOk;
    logic upperSrcOk;
    logic lowerTick;
    logic upperTick;
    logic ovfUpper;
    logic ovfLower;
    logic pulseTick;
    logic [2:0] pulseSel;
    logic [2:0] setMask;
    logic [2:0] clearMask;
    logic [31:0] readValue;
    logic addrValid;

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------

    // Subclock modes: prescaled phi is absent there
    assign lowPower = (powerMode == ecgate_pkg::PM_WATCH) || (powerMode == ecgate_pkg::PM_SUBACTIVE)
        || (powerMode == ecgate_pkg::PM_SUBSLEEP) || (powerMode == ecgate_pkg::PM_STANDBY);
    assign watchStby = (powerMode == ecgate_pkg::PM_WATCH) || (powerMode == ecgate_pkg::PM_STANDBY);

    // Writes are dropped in module standby so settings are held
    assign wrEn = psel && penable && pwrite && !moduleStandby;
    assign wrAddr = paddr;

    // ----------------------------------------
    // Prescaler and pulse generator
    // ----------------------------------------

    // Free prescaler stops with the module clock
    always_ff @(posedge clk) begin
        if (reset) begin
            prescale_reg <= 6'h00;
        end else if (!moduleStandby) begin
            prescale_reg <= prescale_reg + 6'h01;
        end
    end

    // Out-of-range selections clamp to the slowest rate
    assign pulseSel = (pulseClkSel_reg > `ECG_PCLK_MAX) ? `ECG_PCLK_MAX : pulseClkSel_reg;
    assign pulseTick = divTick(prescale_reg, pulseSel);

    // Values are trusted as programmed: data below compare, static while running
    pulse_gen_core #(
        .WIDTH(PULSE_WIDTH)
    ) pulseGen (
        .clk(clk),
        .reset(reset),
        .run(pulseGateSelect_reg),
        .hold(lowPower || moduleStandby),
        .tick(pulseTick),
        .compareValue(pulseCompare_reg),
        .dataValue(pulseData_reg),
        .pulseOut(pulseOut)
    );

    // ----------------------------------------
    // Gate selection and counters
    // ----------------------------------------

    // Abrupt gating can lose or split one count at the edge
    assign gateSignal = pulseGateSelect_reg ? pulseOut : externalGatePin;

    // Event inputs are sampled; a rising edge is one event
    always_ff @(posedge clk) begin
        if (reset) begin
            upperEvtPrev_reg <= 1'b0;
            lowerEvtPrev_reg <= 1'b0;
        end else begin
            upperEvtPrev_reg <= upperEventInput;
            lowerEvtPrev_reg <= lowerEventInput;
        end
    end
    assign upperEdge = upperEventInput && !upperEvtPrev_reg;
    assign lowerEdge = lowerEventInput && !lowerEvtPrev_reg;

    // Prescaled sources die in subclock modes; events keep counting
    always_comb begin
        lowerSrcOk = 1'b0;
        if (lowerSrc_reg == 2'b00) begin
            lowerSrcOk = lowerEdge;
        end else if (!lowPower) begin
            lowerSrcOk = divTick(prescale_reg, 3'(lowerSrc_reg) - 3'h1);
        end
    end

    // Gate applies to both counters at once
    assign lowerTick = lowerSrcOk && lowerCountEnable_reg && lowerRelease_reg
        && gateSignal && !moduleStandby;
    // Chained mode assumes upper enable is not toggled while running
    assign upperSrcOk = splitMode_reg ? upperEdge : (lowerTick && lowerCount_reg == 8'hff);
    assign upperTick = upperSrcOk && upperCountEnable_reg && upperRelease_reg
        && gateSignal && !moduleStandby;

    // Overflow flags are frozen in watch and standby
    assign ovfUpper = upperTick && upperCount_reg == 8'hff && !watchStby;
    assign ovfLower = splitMode_reg && lowerTick && lowerCount_reg == 8'hff && !watchStby;

    // Release low keeps a counter cleared; module standby freezes both, a pending clear too
    always_ff @(posedge clk) begin
        if (reset) begin
            lowerCount_reg <= 8'h00;
            upperCount_reg <= 8'h00;
        end else if (!moduleStandby) begin
            if (!lowerRelease_reg) begin
                lowerCount_reg <= 8'h00;
            end else if (lowerTick) begin
                lowerCount_reg <= lowerCount_reg + 8'h01;
            end
            if (!upperRelease_reg) begin
                upperCount_reg <= 8'h00;
            end else if (upperTick) begin
                upperCount_reg <= upperCount_reg + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Gate interrupt
    // ----------------------------------------

    // Registered copy of the gate; costs one cycle of skew
    always_ff @(posedge clk) begin
        if (reset) begin
            gatePrev_reg <= 1'b0;
        end else begin
            gatePrev_reg <= gateSignal;
        end
    end

    // Pin-sourced interrupts are silent in watch and standby
    assign irqAllowed = !moduleStandby && !(watchStby && !pulseGateSelect_reg);
    assign gateEvent = irqAllowed
        && edgeHit(gateEdgeSel_reg, gateSignal && !gatePrev_reg, !gateSignal && gatePrev_reg);

    // Set wins over a same-cycle write-one clear
    assign setMask = {ovfLower, ovfUpper, gateEvent};
    assign clearMask = (wrEn && wrAddr == `ECG_ISTAT_OFS) ? pwdata[2:0] : 3'h0;
    always_ff @(posedge clk) begin
        if (reset) begin
            irqStatus_reg <= 3'h0;
        end else begin
            irqStatus_reg <= (irqStatus_reg & ~clearMask) | setMask;
        end
    end

    // Level request while any unmasked flag stands
    assign irq = |(irqStatus_reg & irqMask_reg);

    // ----------------------------------------
    // Register writes
    // ----------------------------------------

    // Control and configuration
    always_ff @(posedge clk) begin
        if (reset) begin
            pulseGateSelect_reg <= 1'b0;
            gateEdgeSel_reg <= 2'b00;
            pulseClkSel_reg <= 3'h0;
        end else if (wrEn && wrAddr == `ECG_CTRL_OFS) begin
            pulseGateSelect_reg <= pwdata[`ECG_PGS_BIT];
            gateEdgeSel_reg <= pwdata[`ECG_EDGE_LSB +: 2];
            pulseClkSel_reg <= pwdata[`ECG_PCLK_LSB +: 3];
        end
    end

    // Counter enables, releases and source
    always_ff @(posedge clk) begin
        if (reset) begin
            upperCountEnable_reg <= 1'b0;
            lowerCountEnable_reg <= 1'b0;
            upperRelease_reg <= 1'b0;
            lowerRelease_reg <= 1'b0;
            splitMode_reg <= 1'b0;
            lowerSrc_reg <= 2'b00;
        end else if (wrEn && wrAddr == `ECG_CNT_OFS) begin
            upperCountEnable_reg <= pwdata[`ECG_UCE_BIT];
            lowerCountEnable_reg <= pwdata[`ECG_LCE_BIT];
            upperRelease_reg <= pwdata[`ECG_URL_BIT];
            lowerRelease_reg <= pwdata[`ECG_LRL_BIT];
            splitMode_reg <= pwdata[`ECG_SPLIT_BIT];
            lowerSrc_reg <= pwdata[`ECG_LSRC_LSB +: 2];
        end
    end

    // Pulse values and interrupt mask
    always_ff @(posedge clk) begin
        if (reset) begin
            pulseCompare_reg <= `ECG_PCMP_RST;
            pulseData_reg <= `ECG_PDAT_RST;
            irqMask_reg <= 3'h0;
        end else if (wrEn) begin
            if (wrAddr == `ECG_PCMP_OFS) begin
                pulseCompare_reg <= pwdata[PULSE_WIDTH-1:0];
            end
            if (wrAddr == `ECG_PDAT_OFS) begin
                pulseData_reg <= pwdata[PULSE_WIDTH-1:0];
            end
            if (wrAddr == `ECG_IMASK_OFS) begin
                irqMask_reg <= pwdata[2:0];
            end
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------

    // Counter readback is only coherent with counting stopped
    always_comb begin
        readValue = 32'h0000_0000;
        addrValid = 1'b1;
        case (paddr)
            `ECG_CTRL_OFS: readValue = {26'h0, pulseClkSel_reg, gateEdgeSel_reg, pulseGateSelect_reg};
            `ECG_CNT_OFS: readValue = {25'h0, lowerSrc_reg, splitMode_reg, lowerRelease_reg,
                upperRelease_reg, lowerCountEnable_reg, upperCountEnable_reg};
            `ECG_PCMP_OFS: readValue = 32'(pulseCompare_reg);
            `ECG_PDAT_OFS: readValue = 32'(pulseData_reg);
            `ECG_COUNT_OFS: readValue = {16'h0, upperCount_reg, lowerCount_reg};
            `ECG_ISTAT_OFS: readValue = {29'h0, irqStatus_reg};
            `ECG_IMASK_OFS: readValue = {29'h0, irqMask_reg};
            `ECG_VEC_OFS: readValue = {8'h0, `ECG_VEC_ADDR, `ECG_VEC_NUM};
            default: addrValid = 1'b0;
        endcase
    end

    // Data captured in setup so the access phase ends at once
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : readValue;
            pslverr_reg <= !addrValid;
        end
    end

    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign pready = 1'b1;
    assign internalPulseOutput = pulseOut;
    assign upperEventCount = upperCount_reg;
    assign lowerEventCount = lowerCount_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    pulse_gate_a: assert property (@(posedge clk) disable iff (reset)
        (pulseGateSelect_reg && !pulseOut && lowerRelease_reg) |=> $stable(lowerCount_reg))
        else $error("lower counter moved while pulse gate low");
    pin_gate_a: assert property (@(posedge clk) disable iff (reset)
        (!pulseGateSelect_reg && !externalGatePin && upperRelease_reg) |=> $stable(upperCount_reg))
        else $error("upper counter moved while gate pin low");
    joint_gate_a: assert property (@(posedge clk) disable iff (reset)
        (!gateSignal && upperRelease_reg && lowerRelease_reg)
        |=> ($stable(upperCount_reg) && $stable(lowerCount_reg)))
        else $error("counters not gated together");
    gate_flag_a: assert property (@(posedge clk) disable iff (reset)
        gateEvent |=> irqStatus_reg[`ECG_IRQ_GATE])
        else $error("gate event lost");
    irq_forward_a: assert property (@(posedge clk) disable iff (reset)
        ($rose(irqStatus_reg[`ECG_IRQ_GATE]) && irqMask_reg[`ECG_IRQ_GATE]) |-> irq)
        else $error("enabled gate request not forwarded");
    edge_select_a: assert property (@(posedge clk) disable iff (reset)
        (gateEdgeSel_reg == `ECG_EDGE_RISE && !gateSignal && gatePrev_reg) |-> !gateEvent)
        else $error("falling edge taken in rising mode");
    ovf_freeze_a: assert property (@(posedge clk) disable iff (reset)
        (watchStby && !(wrEn && wrAddr == `ECG_ISTAT_OFS)) |=> $stable(irqStatus_reg[2:1]))
        else $error("overflow flag changed in watch or standby");
    lowpower_src_a: assert property (@(posedge clk) disable iff (reset)
        (lowPower && lowerSrc_reg != 2'b00 && lowerRelease_reg) |=> $stable(lowerCount_reg))
        else $error("prescaled source counted in low power");
    pin_noirq_a: assert property (@(posedge clk) disable iff (reset)
        (watchStby && !pulseGateSelect_reg) |-> !gateEvent)
        else $error("gate pin interrupt in watch or standby");
    standby_hold_a: assert property (@(posedge clk) disable iff (reset)
        moduleStandby |=> ($stable(pulseCompare_reg) && $stable(pulseGateSelect_reg)
        && $stable(lowerCount_reg) && $stable(upperCount_reg)))
        else $error("state changed in module standby");
endmodule

// File: sim/gate_event_source.sv
// Behavioural model of the gate pin and the two event inputs
`timescale 1ns/10ps
module gate_event_source (
    // Clock
    input wire logic clk,
    // Pins toward the block
    output logic externalGatePin,
    output logic upperEventInput,
    output logic lowerEventInput
);
    // Pins rest low so no stray edge is seen after reset
    initial begin
        externalGatePin = 1'b0;
        upperEventInput = 1'b0;
        lowerEventInput = 1'b0;
    end

    // Level change, then a settling gap so the registered gate copy and the gate flag have caught up
    task automatic setGate(input logic level);
        @(posedge clk);
        externalGatePin <= level;
        repeat (4) @(posedge clk);
    endtask

    // Events on both inputs; width lets the source be prompt or slow
    task automatic sendEvents(input int count, input int width);
        for (int i = 0; i < count; i++) begin
            @(posedge clk);
            upperEventInput <= 1'b1;
            lowerEventInput <= 1'b1;
            repeat (width) @(posedge clk);
            upperEventInput <= 1'b0;
            lowerEventInput <= 1'b0;
            repeat (width) @(posedge clk);
        end
    endtask
endmodule

// File: sim/event_counter_gate_and_pwm_test.sv
// Self-checking bench for the event counter gate block
`timescale 1ns/10ps
`include "ecgate_cfg.svh"
module event_counter_gate_and_pwm_test;
    // Stimulus and observed signals
    logic clk, reset, psel, penable, pwrite, pready, pslverr, irq, pulseOut, gatePin, upIn, loIn, standby;
    logic [7:0] paddr, upCount, loCount;
    logic [31:0] pwdata, prdata;
    ecgate_pkg::power_mode_type powerMode;
    logic [32:0] expQ[$];
    int num_errors, checked, onLen, offLen, junk, tper, cmpV, datV, pclk;
    logic expBit;

    event_counter_gate dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .powerMode(powerMode), .moduleStandby(standby), .externalGatePin(gatePin),
        .upperEventInput(upIn), .lowerEventInput(loIn), .internalPulseOutput(pulseOut),
        .upperEventCount(upCount), .lowerEventCount(loCount), .irq(irq));

    gate_event_source src (.clk(clk), .externalGatePin(gatePin), .upperEventInput(upIn),
        .lowerEventInput(loIn));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // Checking and reporting
    // ----------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Read results are matched in bus order against the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
            check({pslverr, prdata}, expQ.pop_front());
        end
    end

    // Hang guard well beyond the longest pulse off time used
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        test_done;
    end

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
        int n;
        n = 0;
        if (!wr) expQ.push_back(exp);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            test_done;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, {1'b0, exp});
    endtask

    // Counts negedges while the pulse output holds the given level
    task automatic measure(input logic lvl, output int n);
        n = 0;
        while (pulseOut === lvl && n < 5000) begin
            @(negedge clk);
            n++;
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        standby = 1'b0;
        powerMode = ecgate_pkg::PM_ACTIVE;
        junk = $urandom(32'h6985);
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        // Reset values, vector word and an unmapped address
        rd(`ECG_CTRL_OFS, 32'h0);
        rd(`ECG_PCMP_OFS, 32'h0000ffff);
        rd(`ECG_IMASK_OFS, 32'h0);
        rd(`ECG_VEC_OFS, 32'h00000c06);
        apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
        // Pin gating: split counters fed from the event inputs
        wr(`ECG_CNT_OFS, 32'h1f);
        src.setGate(1'b1);
        src.sendEvents(3, $urandom_range(1, 3));
        src.setGate(1'b0);
        src.sendEvents(2, 1);
        wr(`ECG_CNT_OFS, 32'h1c);
        rd(`ECG_COUNT_OFS, 32'h0303);
        // Gate interrupt for each edge code, with the request enabled
        wr(`ECG_IMASK_OFS, 32'h1);
        for (int e = 0; e < 3; e++) begin
            wr(`ECG_CTRL_OFS, 32'(e) << 1);
            wr(`ECG_ISTAT_OFS, 32'h7);
            for (int lvl = 1; lvl >= 0; lvl--) begin
                src.setGate(lvl[0]);
                @(negedge clk);
                expBit = (e == 2) || (e == 1 && lvl == 1) || (e == 0 && lvl == 0);
                check({32'h0, irq}, {32'h0, expBit});
                rd(`ECG_ISTAT_OFS, {31'h0, expBit});
                wr(`ECG_ISTAT_OFS, 32'h1);
            end
        end
        // Flag still sets with the request masked, but no request leaves
        wr(`ECG_IMASK_OFS, 32'h0);
        src.setGate(1'b1);
        @(negedge clk);
        check({32'h0, irq}, 33'h0);
        rd(`ECG_ISTAT_OFS, 32'h1);
        wr(`ECG_ISTAT_OFS, 32'h1);
        // Watch mode: events still counted, pin edges raise nothing
        wr(`ECG_CNT_OFS, 32'h1f);
        @(posedge clk);
        powerMode <= ecgate_pkg::PM_WATCH;
        src.setGate(1'b0);
        src.setGate(1'b1);
        src.sendEvents(2, 2);
        @(posedge clk);
        powerMode <= ecgate_pkg::PM_ACTIVE;
        wr(`ECG_CNT_OFS, 32'h1c);
        rd(`ECG_COUNT_OFS, 32'h0505);
        rd(`ECG_ISTAT_OFS, 32'h0);
        // Module standby: counting stops and writes leave registers alone
        wr(`ECG_CNT_OFS, 32'h1f);
        @(posedge clk);
        standby <= 1'b1;
        wr(`ECG_PDAT_OFS, 32'h55);
        src.sendEvents(2, 1);
        @(posedge clk);
        standby <= 1'b0;
        wr(`ECG_CNT_OFS, 32'h1c);
        rd(`ECG_COUNT_OFS, 32'h0505);
        rd(`ECG_PDAT_OFS, 32'h0);
        // Subactive mode: a prescaled lower source in the 16-bit chain stays still
        @(posedge clk);
        powerMode <= ecgate_pkg::PM_SUBACTIVE;
        wr(`ECG_CNT_OFS, 32'h2f);
        repeat (20) @(posedge clk);
        wr(`ECG_CNT_OFS, 32'h0c);
        @(posedge clk);
        powerMode <= ecgate_pkg::PM_ACTIVE;
        rd(`ECG_COUNT_OFS, 32'h0505);
        check(33'({upCount, loCount}), 33'h0505);
        // Pulse selected with a long off time blocks counting despite a high pin
        wr(`ECG_CNT_OFS, 32'h1f);
        wr(`ECG_PCMP_OFS, 32'h100);
        wr(`ECG_PDAT_OFS, 32'hff);
        wr(`ECG_CTRL_OFS, 32'h29);
        src.sendEvents(3, 1);
        wr(`ECG_CNT_OFS, 32'h1c);
        rd(`ECG_COUNT_OFS, 32'h0505);
        // Pulse shape for random source clocks and values
        for (int i = 0; i < 3; i++) begin
            pclk = $urandom_range(0, 2);
            cmpV = $urandom_range(3, 9);
            datV = $urandom_range(0, cmpV - 1);
            tper = 2 << pclk;
            wr(`ECG_CTRL_OFS, 32'h0);
            wr(`ECG_PCMP_OFS, 32'(cmpV));
            wr(`ECG_PDAT_OFS, 32'(datV));
            wr(`ECG_CTRL_OFS, 32'h1 | (32'(pclk) << 3));
            @(negedge clk);
            measure(1'b0, junk);
            measure(1'b1, onLen);
            measure(1'b0, offLen);
            check(33'(offLen), 33'(tper * (datV + 1)));
            check(33'(onLen + offLen), 33'(tper * (cmpV + 1)));
        end
        test_done;
    end
endmodule
